// *** urp_pkg.sv ***
`default_nettype none

package urp_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int RESET_MS = 10;
  localparam int RESUME_MS = 20;
  localparam int RESYNC_MS = 3;
  localparam int EOP_NS = 1333;
  localparam int RESET_CYC = RESET_MS * CLK_MHZ * 1000;
  localparam int RESUME_CYC = RESUME_MS * CLK_MHZ * 1000;
  localparam int RESYNC_CYC = RESYNC_MS * CLK_MHZ * 1000;
  localparam int EOP_CYC = (EOP_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 24;

  // ==========================================================
  // Bus map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_PORT = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h4;

  // ==========================================================
  // Port status read fields
  localparam int B_CCS = 0;
  localparam int B_PES = 1;
  localparam int B_PSS = 2;
  localparam int B_POCI = 3;
  localparam int B_PRS = 4;
  localparam int B_PPS = 8;
  localparam int B_LSDA = 9;
  localparam int B_CSC = 16;
  localparam int B_PESC = 17;
  localparam int B_PSSC = 18;
  localparam int B_OCIC = 19;
  localparam int B_PRSC = 20;

  // ==========================================================
  // Port status write commands
  localparam int W_CLR_EN = 0;
  localparam int W_SET_EN = 1;
  localparam int W_SET_SUSP = 2;
  localparam int W_RESUME = 3;
  localparam int W_SET_RST = 4;
  localparam int W_SET_PWR = 8;
  localparam int W_CLR_PWR = 9;

  // ==========================================================
  // Control register fields
  localparam int C_MODE = 0;
  localparam int C_MASK = 1;
  localparam int C_SET_GPWR = 8;
  localparam int C_CLR_GPWR = 9;

  // ==========================================================
  // Port sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RESET = 3'b001,
    S_RESUME = 3'b010,
    S_EOP = 3'b011,
    S_RESYNC = 3'b100
  } urp_state_type;
endpackage : urp_pkg

// ============================================================
// Down-counting interval timer
module urp_timer #(
  parameter int W = urp_pkg::TMR_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
  } urp_tmr_type;

  urp_tmr_type s_q;
  urp_tmr_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (i_load) begin
      s_d.cnt = i_count;
      s_d.run = 1'b1;
    end else if (s_q.run) begin
      if (s_q.cnt <= W'(1)) begin
        s_d.done = 1'b1;
        s_d.run = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_done = s_q.done;
endmodule : urp_timer

`default_nettype wire

// *** urp_port.sv ***
`default_nettype none

module urp_port #(
  parameter bit PER_PORT_OC = 1'b1,
  parameter bit POWER_SWITCH = 1'b1,
  parameter int unsigned RESET_CYC = urp_pkg::RESET_CYC,
  parameter int unsigned RESUME_CYC = urp_pkg::RESUME_CYC,
  parameter int unsigned RESYNC_CYC = urp_pkg::RESYNC_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [urp_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_connect,
  input wire logic i_low_speed,
  input wire logic i_over_current,
  input wire logic i_babble,
  input wire logic i_nonremovable,
  input wire logic i_xact_busy,
  output logic o_port_power,
  output logic o_port_reset,
  output logic o_port_resume,
  output logic o_port_eop
);
  // ==========================================================
  // Helpers
  function automatic logic upd(input logic flag, input logic set, input logic clr);
    upd = (flag & ~clr) | set;
  endfunction : upd

  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lanes

  function automatic logic hit(input logic [urp_pkg::ADDR_W-1:0] a,
    input logic [urp_pkg::ADDR_W-1:0] base);
    hit = (a == base);
  endfunction : hit

  // ==========================================================
  // State
  typedef struct packed {
    urp_pkg::urp_state_type st;
    logic waitreq;
    logic [31:0] rdata;
    logic init;
    logic mode;
    logic mask;
    logic pps;
    logic ccs;
    logic pes;
    logic pss;
    logic oc;
    logic csc;
    logic pesc;
    logic pssc;
    logic ocic;
    logic prsc;
    logic drv_rst;
    logic drv_resume;
    logic drv_eop;
  } urp_port_type;

  urp_port_type s_q;
  urp_port_type s_d;

  // ==========================================================
  // Interval timer
  logic t_load;
  logic [urp_pkg::TMR_W-1:0] t_count;
  logic t_done;

  urp_timer #(
    .W(urp_pkg::TMR_W)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(t_load),
    .i_count(t_count),
    .o_done(t_done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic wr_go;
    logic wp;
    logic wc;
    logic [31:0] wd;
    logic [31:0] rv;
    logic port_cmd;
    logic set_pwr;
    logic clr_pwr;
    logic pwr;
    logic ccs_new;
    logic oc_new;
    logic misuse;
    logic rst_end;
    logic res_end;
    logic start_rst;
    logic hw_dis;
    wr_go = 1'b0;
    wp = 1'b0;
    wc = 1'b0;
    wd = '0;
    rv = '0;
    port_cmd = 1'b0;
    set_pwr = 1'b0;
    clr_pwr = 1'b0;
    pwr = 1'b0;
    ccs_new = 1'b0;
    oc_new = 1'b0;
    misuse = 1'b0;
    rst_end = 1'b0;
    res_end = 1'b0;
    start_rst = 1'b0;
    hw_dis = 1'b0;
    t_load = 1'b0;
    t_count = '0;
    s_d = s_q;
    s_d.init = 1'b0;

    // ========================================================
    // Bus write decode
    wr_go = i_avs_write & ~s_q.waitreq;
    wd = i_avs_writedata & lanes(i_avs_byteenable);
    wp = wr_go && hit(i_avs_address, urp_pkg::ADDR_PORT);
    wc = wr_go && hit(i_avs_address, urp_pkg::ADDR_CTRL);
    if (wc) begin
      s_d.mode = wd[urp_pkg::C_MODE];
      s_d.mask = wd[urp_pkg::C_MASK];
    end

    // ========================================================
    // Port power
    port_cmd = s_q.mode & s_q.mask;
    set_pwr = (wp & wd[urp_pkg::W_SET_PWR] & port_cmd)
      | (wc & wd[urp_pkg::C_SET_GPWR] & ~port_cmd);
    clr_pwr = (wp & wd[urp_pkg::W_CLR_PWR] & port_cmd)
      | (wc & wd[urp_pkg::C_CLR_GPWR] & ~port_cmd);
    if (!POWER_SWITCH) begin
      pwr = 1'b1;
    end else if (i_over_current) begin
      pwr = 1'b0;
    end else begin
      pwr = upd(s_q.pps, set_pwr, clr_pwr) & ~clr_pwr;
    end
    s_d.pps = pwr;

    // ========================================================
    // Connect status and change
    ccs_new = pwr & (i_nonremovable | i_connect);
    s_d.ccs = ccs_new;
    misuse = wp & ~s_q.ccs & (wd[urp_pkg::W_SET_RST] | wd[urp_pkg::W_SET_EN]
      | wd[urp_pkg::W_SET_SUSP]);
    s_d.csc = upd(s_q.csc, misuse
      | (~i_nonremovable & (ccs_new ^ s_q.ccs))
      | (s_q.init & i_nonremovable),
      wp & wd[urp_pkg::B_CSC]);

    // ========================================================
    // Over-current indicator
    oc_new = PER_PORT_OC & i_over_current;
    s_d.oc = oc_new;
    s_d.ocic = upd(s_q.ocic, PER_PORT_OC & (oc_new ^ s_q.oc),
      wp & wd[urp_pkg::B_OCIC]);

    // ========================================================
    // Reset and resume sequencer
    rst_end = (s_q.st == urp_pkg::S_RESET) & t_done;
    res_end = (s_q.st == urp_pkg::S_RESYNC) & t_done;
    start_rst = wp & wd[urp_pkg::W_SET_RST] & s_q.ccs;
    if (start_rst) begin
      s_d.st = urp_pkg::S_RESET;
      t_load = 1'b1;
      t_count = urp_pkg::TMR_W'(RESET_CYC);
    end else begin
      case (s_q.st)
        urp_pkg::S_IDLE: begin
          if (wp && wd[urp_pkg::W_RESUME] && s_q.pss) begin
            s_d.st = urp_pkg::S_RESUME;
            t_load = 1'b1;
            t_count = urp_pkg::TMR_W'(RESUME_CYC);
          end
        end
        urp_pkg::S_RESET: begin
          if (t_done) begin
            s_d.st = urp_pkg::S_IDLE;
          end
        end
        urp_pkg::S_RESUME: begin
          if (t_done) begin
            s_d.st = urp_pkg::S_EOP;
            t_load = 1'b1;
            t_count = urp_pkg::TMR_W'(urp_pkg::EOP_CYC);
          end
        end
        urp_pkg::S_EOP: begin
          if (t_done) begin
            s_d.st = urp_pkg::S_RESYNC;
            t_load = 1'b1;
            t_count = urp_pkg::TMR_W'(RESYNC_CYC);
          end
        end
        urp_pkg::S_RESYNC: begin
          if (t_done) begin
            s_d.st = urp_pkg::S_IDLE;
          end
        end
        default: begin
          s_d.st = urp_pkg::S_IDLE;
        end
      endcase
    end

    // ========================================================
    // Enable status and change
    hw_dis = s_q.pes & (i_over_current | ~ccs_new | i_babble | ~pwr);
    s_d.pes = upd(s_q.pes, (wp & wd[urp_pkg::W_SET_EN] & s_q.ccs) | rst_end | res_end,
      wp & wd[urp_pkg::W_CLR_EN]) & ~hw_dis;
    s_d.pesc = upd(s_q.pesc, hw_dis, wp & wd[urp_pkg::B_PESC]);

    // ========================================================
    // Suspend status and change, reset status change
    s_d.pss = upd(s_q.pss, wp & wd[urp_pkg::W_SET_SUSP] & s_q.ccs, rst_end | res_end);
    s_d.pssc = upd(s_q.pssc, res_end, (wp & wd[urp_pkg::B_PSSC]) | rst_end);
    s_d.prsc = upd(s_q.prsc, rst_end, wp & wd[urp_pkg::B_PRSC]);

    // ========================================================
    // Power off drops port state
    if (!pwr) begin
      s_d.pes = 1'b0;
      s_d.pss = 1'b0;
      s_d.st = urp_pkg::S_IDLE;
    end

    // ========================================================
    // Line drive outputs
    s_d.drv_rst = (s_d.st == urp_pkg::S_RESET);
    s_d.drv_resume = (s_d.st == urp_pkg::S_RESUME);
    s_d.drv_eop = (s_d.st == urp_pkg::S_EOP);

    // ========================================================
    // Read value
    if (hit(i_avs_address, urp_pkg::ADDR_PORT)) begin
      rv[urp_pkg::B_CCS] = s_q.ccs;
      rv[urp_pkg::B_PES] = s_q.pes;
      rv[urp_pkg::B_PSS] = s_q.pss;
      rv[urp_pkg::B_POCI] = PER_PORT_OC & i_over_current;
      rv[urp_pkg::B_PRS] = s_q.drv_rst;
      rv[urp_pkg::B_PPS] = s_q.pps | ~POWER_SWITCH;
      rv[urp_pkg::B_LSDA] = i_low_speed & s_q.ccs;
      rv[urp_pkg::B_CSC] = s_q.csc;
      rv[urp_pkg::B_PESC] = s_q.pesc;
      rv[urp_pkg::B_PSSC] = s_q.pssc;
      rv[urp_pkg::B_OCIC] = s_q.ocic;
      rv[urp_pkg::B_PRSC] = s_q.prsc;
    end else if (hit(i_avs_address, urp_pkg::ADDR_CTRL)) begin
      rv[urp_pkg::C_MODE] = s_q.mode;
      rv[urp_pkg::C_MASK] = s_q.mask;
    end else begin
      rv = '0;
    end

    // ========================================================
    // Bus handshake
    if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
    end else if (i_avs_read || (i_avs_write && !i_xact_busy)) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = rv;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.init <= 1'b1;
      s_q.st <= urp_pkg::S_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign o_avs_readdata = s_q.rdata;
  assign o_avs_waitrequest = s_q.waitreq;
  assign o_port_power = s_q.pps;
  assign o_port_reset = s_q.drv_rst;
  assign o_port_resume = s_q.drv_resume;
  assign o_port_eop = s_q.drv_eop;
endmodule : urp_port

`default_nettype wire

// *** urp_port_chk_asserts.sv ***
`default_nettype none

module urp_port_chk #(
  parameter int unsigned RESET_CYC = urp_pkg::RESET_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [urp_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic i_over_current,
  input wire logic i_connect,
  input wire logic i_low_speed,
  input wire logic i_xact_busy,
  input wire logic i_nonremovable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_port_power,
  input wire logic o_port_reset,
  input wire logic o_port_resume,
  input wire logic o_port_eop
);
  // ========
  // Reset length counter
  int cnt_q;
  wire logic rd_ok = !o_avs_waitrequest && i_avs_read;
  wire logic rd_port = rd_ok && i_avs_address == urp_pkg::ADDR_PORT;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= o_port_reset ? cnt_q + 1 : 0;
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ========
  // Properties
  oc_read_a: assert property (
    rd_port |-> o_avs_readdata[3] == $past(i_over_current)) else $error("oc bit");
  rsvd_zero_a: assert property (
    rd_ok |-> (o_avs_readdata & 32'hffe0fce0) == 32'h0) else $error("reserved");
  oc_power_a: assert property (
    i_over_current |-> ##[1:2] !o_port_power) else $error("oc power");
  rst_len_a: assert property (
    $fell(o_port_reset) && o_port_power |-> cnt_q + 1 >= RESET_CYC && cnt_q <= RESET_CYC + 2)
    else $error("reset length");
  rst_conn_a: assert property (
    $rose(o_port_reset) |-> $past(i_connect || i_nonremovable, 2))
    else $error("reset disconnected");
  off_idle_a: assert property (
    !o_port_power |=> !o_port_reset && !o_port_resume) else $error("power off");
  eop_next_a: assert property (
    $fell(o_port_resume) && o_port_power && !o_port_reset |-> o_port_eop)
    else $error("eop");
  busy_hold_a: assert property (
    i_xact_busy && i_avs_write && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("busy write");
  ls_read_a: assert property (
    rd_port && o_avs_readdata[0] |-> o_avs_readdata[9] == $past(i_low_speed))
    else $error("speed bit");
endmodule : urp_port_chk

bind urp_port urp_port_chk #(.RESET_CYC(RESET_CYC)) u_chk (.i_clk, .i_rst, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_over_current, .i_connect, .i_low_speed, .i_xact_busy,
  .i_nonremovable,
  .o_avs_readdata, .o_avs_waitrequest, .o_port_power, .o_port_reset, .o_port_resume,
  .o_port_eop);

`default_nettype wire

// *** urp_dev.sv ***
`default_nettype none

module urp_dev (
  input wire logic i_plug,
  input wire logic i_ls,
  input wire logic i_run,
  output logic o_connect,
  output logic o_low_speed,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Line levels, connect and low speed pulled down when unplugged; busy follows i_run
  assign o_connect = i_plug;
  assign o_low_speed = i_plug & i_ls;
  assign o_busy = i_run;
endmodule : urp_dev

`default_nettype wire

// *** tb_top.sv ***
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rd, wr, plug, ls, oc, bab, run, conn, lsp, busy, wq, pwr, prst, pres;
  logic nrm, eop;
  logic [3:0] adr;
  logic [31:0] wd, rdat, q;
  int n_errors = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  urp_dev u_dev (.i_plug(plug), .i_ls(ls), .i_run(run), .o_connect(conn),
    .o_low_speed(lsp), .o_busy(busy));
  urp_port #(.RESET_CYC(200), .RESUME_CYC(300), .RESYNC_CYC(100)) u_dut (.i_clk(clk),
    .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .i_connect(conn), .i_low_speed(lsp), .i_over_current(oc),
    .i_babble(bab), .i_nonremovable(nrm), .i_xact_busy(busy), .o_port_power(pwr),
    .o_port_reset(prst), .o_port_resume(pres), .o_port_eop(eop));
  // ========
  // Tasks
  task automatic results;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(0, a, 32'h0);
    chk(q, e, m);
  endtask : rc
  // ========
  // Tests
  initial begin
    int n;
    clk = 0; rst = 1; adr = 0; rd = 0; wr = 0; wd = 0;
    plug = 0; ls = 0; oc = 0; bab = 0; run = 0;
    nrm = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc(4'h0, 32'h0, 32'hffffffff);
    rc(4'h8, 32'h0, 32'hffffffff);
    $display("test idle done");
    bus(1, 4'h0, 32'h100);
    rc(4'h0, 32'h0, 32'h100);
    bus(1, 4'h4, 32'h100);
    rc(4'h0, 32'h100, 32'h100);
    bus(1, 4'h4, 32'h3);
    bus(1, 4'h0, 32'h200);
    rc(4'h0, 32'h0, 32'h100);
    bus(1, 4'h0, 32'h100);
    rc(4'h0, 32'h100, 32'h100);
    $display("test power done");
    plug <= 1'b1;
    ls <= 1'b1;
    repeat (4) @(posedge clk);
    rc(4'h0, 32'h10301, 32'h10301);
    bus(1, 4'h0, 32'h10000);
    rc(4'h0, 32'h0, 32'h10000);
    bus(1, 4'h0, 32'h10);
    rc(4'h0, 32'h10, 32'h10);
    chk({31'h0, prst}, 32'h1, 32'h1);
    n = 0;
    do begin
      bus(0, 4'h0, 32'h0);
      n++;
    end while (q[20] !== 1'b1 && n < 200);
    chk(q, 32'h100002, 32'h100012);
    bus(1, 4'h0, 32'h100000);
    rc(4'h0, 32'h0, 32'h100000);
    $display("test reset done");
    bab <= 1'b1;
    repeat (3) @(posedge clk);
    bab <= 1'b0;
    rc(4'h0, 32'h20000, 32'h20002);
    bus(1, 4'h0, 32'h20000);
    bus(1, 4'h0, 32'h8);
    repeat (3) @(posedge clk);
    chk({31'h0, pres}, 32'h0, 32'h1);
    bus(1, 4'h0, 32'h4);
    bus(1, 4'h0, 32'h8);
    @(posedge clk);
    chk({31'h0, pres}, 32'h1, 32'h1);
    n = 0;
    while (eop !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, eop}, 32'h1, 32'h1);
    n = 0;
    do begin
      bus(0, 4'h0, 32'h0);
      n++;
    end while (q[18] !== 1'b1 && n < 400);
    chk(q, 32'h40002, 32'h40006);
    $display("test resume done");
    run <= 1'b1;
    fork
      bus(1, 4'h0, 32'h200);
    join_none
    repeat (6) @(posedge clk);
    chk({31'h0, pwr}, 32'h1, 32'h1);
    run <= 1'b0;
    wait fork;
    repeat (2) @(posedge clk);
    chk({31'h0, pwr}, 32'h0, 32'h1);
    bus(1, 4'h0, 32'h100);
    plug <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1, 4'h0, 32'h10000);
    bus(1, 4'h0, 32'h10);
    rc(4'h0, 32'h10000, 32'h10011);
    oc <= 1'b1;
    repeat (4) @(posedge clk);
    rc(4'h0, 32'h80008, 32'h80108);
    $display("test fault done");
    oc <= 1'b0;
    nrm <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(4'h0, 32'h10000, 32'h10101);
    bus(1, 4'h0, 32'h10000);
    bus(1, 4'h4, 32'h100);
    repeat (2) @(posedge clk);
    rc(4'h0, 32'h101, 32'h10101);
    $display("test nonremovable done");
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("BAD %0t timeout", $time);
    results();
  end
endmodule : tb_top

`default_nettype wire
